// ===== design/pulse_shaper_pkg.sv
// Constants, field layouts and carrier types of the pulse shaper register group
`default_nettype none

package pulse_shaper_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int NUM_CH = 8;
  localparam int CH_W = 3;
  localparam int CELL_W = 7;
  localparam int IDX_W = 5;
  localparam int NUM_CELLS = 32;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int SPU_W = 4;
  localparam int SUM_W = 8;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_LOS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_DRV_FAIL_STATUS = 8'h05;
  localparam logic [ADDR_W-1:0] ADDR_LOS_IE = 8'h06;
  localparam logic [ADDR_W-1:0] ADDR_DRV_FAIL_IE = 8'h07;
  localparam logic [ADDR_W-1:0] ADDR_LOS_IS = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_DRV_FAIL_IS = 8'h09;
  localparam logic [ADDR_W-1:0] ADDR_AIS_STATUS = 8'h13;
  localparam logic [ADDR_W-1:0] ADDR_AIS_IE = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_AIS_IS = 8'h15;
  localparam logic [ADDR_W-1:0] ADDR_MULTI_WR = 8'h16;
  localparam logic [ADDR_W-1:0] ADDR_PHASE_ADDR = 8'h17;
  localparam logic [ADDR_W-1:0] ADDR_SAMPLE_DATA = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_SOURCE_SEL = 8'h19;
  localparam logic [ADDR_W-1:0] ADDR_OVF_IE = 8'h1a;
  localparam logic [ADDR_W-1:0] ADDR_OVF_IS = 8'h1b;
  localparam logic [ADDR_W-1:0] ADDR_RESERVED_FIRST_FIRST = 8'h1c;
  localparam logic [ADDR_W-1:0] ADDR_RESERVED_FIRST_SECOND = 8'h1d;
  localparam logic [ADDR_W-1:0] ADDR_TIMING_REC = 8'h1e;
  localparam logic [ADDR_W-1:0] ADDR_RESERVED_FIRST_THIRD = 8'h1f;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int CH_FIELD_HI = 7;
  localparam int CH_FIELD_LO = 5;
  localparam int IDX_FIELD_HI = 4;
  localparam int IDX_FIELD_LO = 0;
  localparam int SAMPLE_PAD_BIT = 7;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic [CELL_W-1:0] CELL_RESET = 7'h00;
  localparam logic [CELL_W-1:0] SAMPLE_MAX = 7'h3f;
  localparam logic [CELL_W-1:0] SAMPLE_MIN = 7'h40;

  // ----------------------------------------------------------------
  // Interrupt groups
  // ----------------------------------------------------------------
  localparam int NUM_GRP = 4;
  localparam int GRP_LOS = 0;
  localparam int GRP_DRV_FAIL = 1;
  localparam int GRP_AIS = 2;
  localparam int GRP_OVF = 3;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef logic [NUM_CH-1:0] chan_mask_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_s;

  typedef struct packed {
    chan_mask_t signal_loss;
    chan_mask_t driver_fail_monitor;
    chan_mask_t alarm_indication;
  } line_status_s;

endpackage

`default_nettype wire

// ===== design/level_sync.sv
// Two-stage synchroniser for asynchronous status levels
`default_nettype none

module level_sync
  import pulse_shaper_pkg::*;
#(
  parameter int WIDTH = 3 * NUM_CH
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule

`default_nettype wire

// ===== design/waveform_mem.sv
// Custom waveform sample memory for all channels with per-channel overflow check
`default_nettype none

module waveform_mem
  import pulse_shaper_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic wr_en_i,
  input wire chan_mask_t wr_mask_i,
  input wire logic [IDX_W-1:0] idx_i,
  input wire logic [CELL_W-1:0] wdata_i,
  input wire logic [CH_W-1:0] rd_ch_i,
  input wire logic [SPU_W-1:0] samples_per_ui_i,
  output logic [CELL_W-1:0] rd_data_o,
  output chan_mask_t overflow_o
);

  logic [CELL_W-1:0] cell_q [NUM_CH][NUM_CELLS];
  logic [CELL_W-1:0] cell_d [NUM_CH][NUM_CELLS];
  chan_mask_t ovf_q;
  chan_mask_t ovf_d;

  // Signed seven-bit sum leaves range when the two top sum bits differ
  function automatic logic sum_overflows(input logic [CELL_W-1:0] a, input logic [CELL_W-1:0] b);
    logic [SUM_W-1:0] sum;
    sum = {a[CELL_W-1], a} + {b[CELL_W-1], b};
    return sum[SUM_W-1] != sum[SUM_W-2];
  endfunction

  // ----------------------------------------------------------------
  // Cell writes
  // ----------------------------------------------------------------
  always_comb begin
    cell_d = cell_q;
    for (int c = 0; c < NUM_CH; c++) begin
      if (wr_en_i && wr_mask_i[c]) begin
        cell_d[c][idx_i] = wdata_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // Overflow check
  // ----------------------------------------------------------------
  always_comb begin
    ovf_d = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      for (int k = 0; k < NUM_CELLS; k++) begin
        if (k < int'(samples_per_ui_i) && (k + int'(samples_per_ui_i)) < NUM_CELLS) begin
          if (sum_overflows(cell_q[c][k], cell_q[c][k + int'(samples_per_ui_i)])) begin
            ovf_d[c] = 1'b1;
          end
        end
      end
    end
  end

  // Only a power-up reset reaches the cells
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int c = 0; c < NUM_CH; c++) begin
        for (int k = 0; k < NUM_CELLS; k++) begin
          cell_q[c][k] <= CELL_RESET;
        end
      end
      ovf_q <= '0;
    end else begin
      cell_q <= cell_d;
      ovf_q <= ovf_d;
    end
  end

  assign rd_data_o = cell_q[rd_ch_i][idx_i];
  assign overflow_o = ovf_q;

endmodule

`default_nettype wire

// ===== design/pulse_shaper_and_irq_regs.sv
// Pulse shaper configuration registers and interrupt aggregation
`default_nettype none

module pulse_shaper_and_irq_regs
  import pulse_shaper_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic soft_reset_i,
  input wire reg_req_s reg_req_i,
  output logic [DATA_W-1:0] rdata_o,
  input wire line_status_s line_status_i,
  input wire logic [SPU_W-1:0] samples_per_ui_i,
  output chan_mask_t waveform_source_bits_o,
  output chan_mask_t timing_recovery_o,
  output logic int_n_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  line_status_s line_sync;
  chan_mask_t overflow;
  logic [CELL_W-1:0] mem_rd;
  chan_mask_t wr_mask;
  logic sample_wr;

  chan_mask_t multi_channel_write_bits_q, multi_channel_write_bits_d;
  logic [DATA_W-1:0] phase_addr_q, phase_addr_d;
  chan_mask_t source_q, source_d;
  chan_mask_t timing_q, timing_d;

  logic [NUM_GRP-1:0][NUM_CH-1:0] status;
  logic [NUM_GRP-1:0][NUM_CH-1:0] prev_q, prev_d;
  logic [NUM_GRP-1:0][NUM_CH-1:0] ie_q, ie_d;
  logic [NUM_GRP-1:0][NUM_CH-1:0] isr_q, isr_d;
  logic [NUM_GRP-1:0][NUM_CH-1:0] isr_set;
  logic int_n_q, int_n_d;

  logic [DATA_W-1:0] rdata_q, rdata_d;

  // ----------------------------------------------------------------
  // Address decode helpers
  // ----------------------------------------------------------------
  function automatic logic [ADDR_W-1:0] ie_addr(input int g);
    case (g)
      GRP_LOS: return ADDR_LOS_IE;
      GRP_DRV_FAIL: return ADDR_DRV_FAIL_IE;
      GRP_AIS: return ADDR_AIS_IE;
      default: return ADDR_OVF_IE;
    endcase
  endfunction

  function automatic logic [ADDR_W-1:0] isr_addr(input int g);
    case (g)
      GRP_LOS: return ADDR_LOS_IS;
      GRP_DRV_FAIL: return ADDR_DRV_FAIL_IS;
      GRP_AIS: return ADDR_AIS_IS;
      default: return ADDR_OVF_IS;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Status inputs
  // ----------------------------------------------------------------
  level_sync #(
    .WIDTH(3 * NUM_CH)
  ) u_status_sync (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .async_i(line_status_i),
    .sync_o(line_sync)
  );

  // Status follows the condition whatever the masks say
  always_comb begin
    status[GRP_LOS] = line_sync.signal_loss;
    status[GRP_DRV_FAIL] = line_sync.driver_fail_monitor;
    status[GRP_AIS] = line_sync.alarm_indication;
    status[GRP_OVF] = overflow;
  end

  // ----------------------------------------------------------------
  // Waveform memory
  // ----------------------------------------------------------------
  assign sample_wr = reg_req_i.wr && reg_req_i.addr == ADDR_SAMPLE_DATA;

  always_comb begin
    wr_mask = multi_channel_write_bits_q;
    wr_mask[phase_addr_q[CH_FIELD_HI:CH_FIELD_LO]] = 1'b1;
  end

  waveform_mem u_mem (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .wr_en_i(sample_wr),
    .wr_mask_i(wr_mask),
    .idx_i(phase_addr_q[IDX_FIELD_HI:IDX_FIELD_LO]),
    .wdata_i(reg_req_i.wdata[SAMPLE_PAD_BIT-1:0]),
    .rd_ch_i(phase_addr_q[CH_FIELD_HI:CH_FIELD_LO]),
    .samples_per_ui_i(samples_per_ui_i),
    .rd_data_o(mem_rd),
    .overflow_o(overflow)
  );

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_comb begin
    multi_channel_write_bits_d = multi_channel_write_bits_q;
    phase_addr_d = phase_addr_q;
    source_d = source_q;
    timing_d = timing_q;
    if (soft_reset_i) begin
      multi_channel_write_bits_d = REG_RESET;
      phase_addr_d = REG_RESET;
      source_d = REG_RESET;
      timing_d = REG_RESET;
    end else if (reg_req_i.wr) begin
      case (reg_req_i.addr)
        ADDR_MULTI_WR: multi_channel_write_bits_d = reg_req_i.wdata;
        ADDR_PHASE_ADDR: phase_addr_d = reg_req_i.wdata;
        ADDR_SOURCE_SEL: source_d = reg_req_i.wdata;
        ADDR_TIMING_REC: timing_d = reg_req_i.wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      multi_channel_write_bits_q <= REG_RESET;
      phase_addr_q <= REG_RESET;
      source_q <= REG_RESET;
      timing_q <= REG_RESET;
    end else begin
      multi_channel_write_bits_q <= multi_channel_write_bits_d;
      phase_addr_q <= phase_addr_d;
      source_q <= source_d;
      timing_q <= timing_d;
    end
  end

  assign waveform_source_bits_o = source_q;
  assign timing_recovery_o = timing_q;

  // ----------------------------------------------------------------
  // Interrupt groups
  // ----------------------------------------------------------------
  always_comb begin
    prev_d = status;
    ie_d = ie_q;
    isr_d = isr_q;
    isr_set = '0;
    for (int g = 0; g < NUM_GRP; g++) begin
      isr_set[g] = (status[g] ^ prev_q[g]) & ie_q[g];
      if (soft_reset_i) begin
        ie_d[g] = REG_RESET;
        isr_d[g] = REG_RESET;
      end else begin
        if (reg_req_i.wr && reg_req_i.addr == ie_addr(g)) begin
          ie_d[g] = reg_req_i.wdata;
        end
        if (reg_req_i.rd && reg_req_i.addr == isr_addr(g)) begin
          isr_d[g] = REG_RESET;
        end
        isr_d[g] = isr_d[g] | isr_set[g];
      end
    end
    int_n_d = ~(|isr_d);
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prev_q <= '0;
      ie_q <= '0;
      isr_q <= '0;
      int_n_q <= 1'b1;
    end else begin
      prev_q <= prev_d;
      ie_q <= ie_d;
      isr_q <= isr_d;
      int_n_q <= int_n_d;
    end
  end

  assign int_n_o = int_n_q;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb begin
    rdata_d = rdata_q;
    if (reg_req_i.rd) begin
      case (reg_req_i.addr)
        ADDR_LOS_STATUS: rdata_d = status[GRP_LOS];
        ADDR_DRV_FAIL_STATUS: rdata_d = status[GRP_DRV_FAIL];
        ADDR_AIS_STATUS: rdata_d = status[GRP_AIS];
        ADDR_LOS_IE: rdata_d = ie_q[GRP_LOS];
        ADDR_DRV_FAIL_IE: rdata_d = ie_q[GRP_DRV_FAIL];
        ADDR_AIS_IE: rdata_d = ie_q[GRP_AIS];
        ADDR_OVF_IE: rdata_d = ie_q[GRP_OVF];
        ADDR_LOS_IS: rdata_d = isr_q[GRP_LOS];
        ADDR_DRV_FAIL_IS: rdata_d = isr_q[GRP_DRV_FAIL];
        ADDR_AIS_IS: rdata_d = isr_q[GRP_AIS];
        ADDR_OVF_IS: rdata_d = isr_q[GRP_OVF];
        ADDR_MULTI_WR: rdata_d = multi_channel_write_bits_q;
        ADDR_PHASE_ADDR: rdata_d = phase_addr_q;
        ADDR_SAMPLE_DATA: rdata_d = {1'b0, mem_rd};
        ADDR_SOURCE_SEL: rdata_d = source_q;
        ADDR_TIMING_REC: rdata_d = timing_q;
        default: rdata_d = REG_RESET;
      endcase
    end
  end

  // Soft reset leaves the read holding register alone
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_q <= REG_RESET;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata_o = rdata_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_source_write;
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (reg_req_i.wr && reg_req_i.addr == ADDR_SOURCE_SEL && !soft_reset_i)
      |=> waveform_source_bits_o == $past(reg_req_i.wdata);
  endproperty
  a_source_write: assert property (p_source_write)
    else $error("source select did not take written value");

  property p_timing_write;
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (reg_req_i.wr && reg_req_i.addr == ADDR_TIMING_REC && !soft_reset_i)
      |=> timing_recovery_o == $past(reg_req_i.wdata);
  endproperty
  a_timing_write: assert property (p_timing_write)
    else $error("timing recovery enable did not take written value");

  property p_status_read;
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (reg_req_i.rd && reg_req_i.addr == ADDR_LOS_STATUS)
      |=> rdata_o == $past(line_sync.signal_loss);
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("loss status read returned wrong value");

  property p_sample_read;
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (reg_req_i.rd && reg_req_i.addr == ADDR_SAMPLE_DATA)
      |=> rdata_o == {1'b0, $past(mem_rd)};
  endproperty
  a_sample_read: assert property (p_sample_read)
    else $error("sample read did not return addressed cell");

  property p_soft_keeps_data;
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (soft_reset_i && !reg_req_i.rd) |=> $stable(rdata_o);
  endproperty
  a_soft_keeps_data: assert property (p_soft_keeps_data)
    else $error("soft reset disturbed read data");

  property p_change_raises;
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (|((status[GRP_LOS] ^ prev_q[GRP_LOS]) & ie_q[GRP_LOS]) && !soft_reset_i)
      |=> !int_n_o && (isr_q[GRP_LOS] != '0);
  endproperty
  a_change_raises: assert property (p_change_raises)
    else $error("enabled status change did not raise interrupt");

  property p_masked_blocks;
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (ie_q[GRP_AIS] == '0) |=> (isr_q[GRP_AIS] & ~$past(isr_q[GRP_AIS])) == '0;
  endproperty
  a_masked_blocks: assert property (p_masked_blocks)
    else $error("masked alarm group raised a flag");

  property p_ovf_read_clears;
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (reg_req_i.rd && reg_req_i.addr == ADDR_OVF_IS && isr_set[GRP_OVF] == '0)
      |=> isr_q[GRP_OVF] == '0;
  endproperty
  a_ovf_read_clears: assert property (p_ovf_read_clears)
    else $error("overflow flag read did not clear flags");

  property p_ovf_flag_set;
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (isr_set[GRP_OVF] != '0 && !soft_reset_i)
      |=> (isr_q[GRP_OVF] & $past(isr_set[GRP_OVF])) == $past(isr_set[GRP_OVF]);
  endproperty
  a_ovf_flag_set: assert property (p_ovf_flag_set)
    else $error("overflow change not recorded in flags");

  property p_los_read_clears;
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (reg_req_i.rd && reg_req_i.addr == ADDR_LOS_IS && isr_set[GRP_LOS] == '0)
      |=> isr_q[GRP_LOS] == '0;
  endproperty
  a_los_read_clears: assert property (p_los_read_clears)
    else $error("loss interrupt status read did not clear");

  property p_int_level;
    @(posedge clk_sys_i) disable iff (!rstn_i)
    int_n_o == (isr_q == '0);
  endproperty
  a_int_level: assert property (p_int_level)
    else $error("interrupt pin disagrees with pending flags");

endmodule

`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the pulse shaper register group
`default_nettype none

module tb_top
  import pulse_shaper_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic soft_reset_i = 1'b0;
  reg_req_s req = '0;
  logic [DATA_W-1:0] rdata_o;
  logic [2:0][7:0] ls_v = '0;
  logic [SPU_W-1:0] spu = 4'h2;
  chan_mask_t waveform_source_bits_o;
  chan_mask_t timing_recovery_o;
  logic int_n_o;
  int err_total = 0;
  int comparisons = 0;
  logic [7:0] ie_a [3] = '{ADDR_LOS_IE, ADDR_DRV_FAIL_IE, ADDR_AIS_IE};
  logic [7:0] is_a [3] = '{ADDR_LOS_IS, ADDR_DRV_FAIL_IS, ADDR_AIS_IS};
  logic [7:0] st_a [3] = '{ADDR_LOS_STATUS, ADDR_DRV_FAIL_STATUS, ADDR_AIS_STATUS};

  always #4 clk_sys_i = ~clk_sys_i;

  pulse_shaper_and_irq_regs u_dut (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .soft_reset_i(soft_reset_i),
    .reg_req_i(req),
    .rdata_o(rdata_o),
    .line_status_i(line_status_s'(ls_v)),
    .samples_per_ui_i(spu),
    .waveform_source_bits_o(waveform_source_bits_o),
    .timing_recovery_o(timing_recovery_o),
    .int_n_o(int_n_o)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(negedge clk_sys_i);
    req = '0;
  endtask

  task automatic rd(input string n, input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_sys_i);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge clk_sys_i);
    req = '0;
    chk(n, rdata_o, e);
  endtask

  task automatic wait_low();
    int i;
    for (i = 0; i < 20 && int_n_o !== 1'b0; i++) begin
      @(negedge clk_sys_i);
    end
    if (int_n_o !== 1'b0) begin
      err_total++;
      finish_test();
    end
  endtask

  task automatic int_is(input logic e);
    chk("int_n", {7'h00, int_n_o}, {7'h00, e});
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    idle(4);
    rstn_i = 1'b1;
    // Reset values and reserved reads
    rd("src_sel", ADDR_SOURCE_SEL, 8'h00);
    rd("ovf_ie", ADDR_OVF_IE, 8'h00);
    rd("ovf_is", ADDR_OVF_IS, 8'h00);
    rd("timing", ADDR_TIMING_REC, 8'h00);
    rd("sample", ADDR_SAMPLE_DATA, 8'h00);
    int_is(1'b1);
    wr(ADDR_RESERVED_FIRST_FIRST, 8'h00);
    rd("rsvd1", ADDR_RESERVED_FIRST_FIRST, 8'h00);
    rd("rsvd2", ADDR_RESERVED_FIRST_SECOND, 8'h00);
    rd("rsvd3", ADDR_RESERVED_FIRST_THIRD, 8'h00);
    // Configuration registers drive their outputs
    wr(ADDR_SOURCE_SEL, 8'ha5);
    wr(ADDR_TIMING_REC, 8'h5a);
    wr(ADDR_OVF_IE, 8'h3c);
    rd("src_sel", ADDR_SOURCE_SEL, 8'ha5);
    chk("src_out", waveform_source_bits_o, 8'ha5);
    rd("timing", ADDR_TIMING_REC, 8'h5a);
    chk("timing_out", timing_recovery_o, 8'h5a);
    rd("ovf_ie", ADDR_OVF_IE, 8'h3c);
    // Sample cells, pad bit and multi-channel writes
    wr(ADDR_PHASE_ADDR, 8'h43);
    wr(ADDR_SAMPLE_DATA, 8'h7f);
    rd("cell_2_3", ADDR_SAMPLE_DATA, 8'h7f);
    wr(ADDR_MULTI_WR, 8'h10);
    wr(ADDR_PHASE_ADDR, 8'h44);
    wr(ADDR_SAMPLE_DATA, 8'h15);
    wr(ADDR_PHASE_ADDR, 8'h84);
    rd("cell_4_4", ADDR_SAMPLE_DATA, 8'h15);
    wr(ADDR_PHASE_ADDR, 8'h43);
    rd("cell_2_3b", ADDR_SAMPLE_DATA, 8'h7f);
    wr(ADDR_MULTI_WR, 8'h00);
    // Software reset keeps cells, clears configuration
    @(negedge clk_sys_i);
    soft_reset_i = 1'b1;
    @(negedge clk_sys_i);
    soft_reset_i = 1'b0;
    chk("src_out", waveform_source_bits_o, 8'h00);
    chk("timing_out", timing_recovery_o, 8'h00);
    rd("ovf_ie", ADDR_OVF_IE, 8'h00);
    wr(ADDR_PHASE_ADDR, 8'h43);
    rd("cell_kept", ADDR_SAMPLE_DATA, 8'h7f);
    // Line status groups: enabled change, masked change, read-only status
    for (int g = 0; g < 3; g++) begin
      wr(ie_a[g], 8'h01);
      ls_v[2-g] = 8'h01;
      wait_low();
      rd("is_flag", is_a[g], 8'h01);
      int_is(1'b1);
      ls_v[2-g] = 8'h03;
      idle(6);
      int_is(1'b1);
      rd("is_masked", is_a[g], 8'h00);
      rd("status", st_a[g], 8'h03);
      wr(st_a[g], 8'h00);
      rd("status_ro", st_a[g], 8'h03);
    end
    // Two groups pending keep the interrupt low
    ls_v[2] = 8'h02;
    ls_v[0] = 8'h02;
    wait_low();
    idle(4);
    rd("los_is", ADDR_LOS_IS, 8'h01);
    int_is(1'b0);
    rd("ais_is", ADDR_AIS_IS, 8'h01);
    int_is(1'b1);
    // Overflow on channel 0 with two samples per interval
    wr(ADDR_PHASE_ADDR, 8'h00);
    wr(ADDR_SAMPLE_DATA, 8'h3f);
    wr(ADDR_PHASE_ADDR, 8'h02);
    wr(ADDR_SAMPLE_DATA, 8'h01);
    idle(6);
    int_is(1'b1);
    rd("ovf_masked", ADDR_OVF_IS, 8'h00);
    wr(ADDR_OVF_IE, 8'h01);
    wr(ADDR_SAMPLE_DATA, 8'h00);
    wait_low();
    rd("ovf_clear", ADDR_OVF_IS, 8'h01);
    int_is(1'b1);
    wr(ADDR_PHASE_ADDR, 8'h00);
    wr(ADDR_SAMPLE_DATA, 8'h40);
    idle(4);
    int_is(1'b1);
    wr(ADDR_PHASE_ADDR, 8'h02);
    wr(ADDR_SAMPLE_DATA, 8'h7f);
    wait_low();
    rd("ovf_neg", ADDR_OVF_IS, 8'h01);
    int_is(1'b1);
    rd("ovf_again", ADDR_OVF_IS, 8'h00);
    finish_test();
  end

endmodule

`default_nettype wire
